// File: src/tlds_pkg.sv
// Constants and carrier types for the three-lane seven-to-one deserializer.
// Assumes a 100 MHz system clock that oversamples the forwarded link clock.
package tlds_pkg;
  // ==========================================================
  // Geometry
  localparam int LANES = 3;
  localparam int BITS_PER_LANE = 7;
  localparam int WORD_W = LANES * BITS_PER_LANE;
  localparam int CNT_W = 8;
  // ==========================================================
  // Timing, each time in its own unit; sleep, lock and loss times then as cycle counts
  localparam int SYS_CLK_MHZ = 100;
  localparam int LINK_PER_MIN_PS = 11760;
  localparam int LINK_PER_MAX_PS = 83330;
  localparam int SLEEP_ENTRY_NS = 1000;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS * SYS_CLK_MHZ) / 1000;
  localparam int PLL_LOCK_TIME_MS = 10;
  localparam int PLL_LOCK_CYC = PLL_LOCK_TIME_MS * SYS_CLK_MHZ * 1000;
  // Clock declared lost after this long without a rising edge
  localparam int LOSS_NS = 2000;
  localparam logic [CNT_W-1:0] LOSS_CYC =
    CNT_W'((LOSS_NS * SYS_CLK_MHZ) / 1000);
  // Consecutive steady periods needed before the word is trusted
  localparam logic [2:0] LOCK_EDGES = 3'h4;
  // ==========================================================
  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 21'h000000;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    TLDS_SLEEP = 2'b00,
    TLDS_ACQ = 2'b01,
    TLDS_LOCK = 2'b11,
    TLDS_LOST = 2'b10
  } tlds_state_type;

  typedef struct packed {
    logic [WORD_W-1:0] word; // Parallel data word
    logic strobe; // Regenerated strobe clock
  } tlds_out_type;
endpackage

// File: src/tlds_rx.sv
// Three-lane seven-to-one deserializer, receive side.
// Assumes the forwarded clock and lanes arrive asynchronously and are
// oversampled by sys_clk; the link clock is slow enough for that.
`timescale 1ns/1ns
`default_nettype none
module tlds_rx
  import tlds_pkg::*;
#(
  parameter int LOCK_LIMIT_CYC = PLL_LOCK_CYC
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic forwarded_link_clock, // Forwarded clock lane
  input wire logic [LANES-1:0] serial_data_lane, // Serial data lanes
  input wire logic sleep_n, // Power-down request, active low
  output tlds_out_type parallel_word_out // Word and strobe clock
);

  // ==========================================================
  // Input synchronisers
  logic [LANES+1:0] sync1_r, sync2_r;
  logic clk_d_r;
  logic clk_s, sleep_s;
  logic [LANES-1:0] lane_s, lane_d_r;

  // Two flops per pin before the receive logic reads it; the check counter reads sleep_n raw
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      clk_d_r <= 1'b0;
      lane_d_r <= '0;
    end else begin
      sync1_r <= {sleep_n, forwarded_link_clock, serial_data_lane};
      sync2_r <= sync1_r;
      clk_d_r <= sync2_r[LANES];
      // Lanes lag one more cycle so count zero sees the edge's own sample
      lane_d_r <= lane_s;
    end
  end

  assign lane_s = sync2_r[LANES-1:0];
  assign clk_s = sync2_r[LANES];
  assign sleep_s = sync2_r[LANES+1];

  // ==========================================================
  // Bit sample positions from the last two measured periods
  logic [CNT_W-1:0] cnt_r, cnt_nxt, per_r, per_nxt, prev_r, prev_nxt;
  logic [BITS_PER_LANE-1:0] hit;
  logic [CNT_W:0] two_per;

  // Two periods summed: a single period is only known to +-1 cycle,
  // which at under two samples per bit pushes the last bits off centre
  assign two_per = {1'b0, per_r} + {1'b0, prev_r};
  // Centre of bit k is two_per*(2k+1)/28 cycles after the rising edge
  for (genvar k = 0; k < BITS_PER_LANE; k++) begin : g_pos
    logic [CNT_W+4:0] prod;
    assign prod = {4'h0, two_per} * (CNT_W+5)'(2 * k + 1);
    assign hit[k] = (cnt_r == CNT_W'(prod / (4 * BITS_PER_LANE)));
  end

  // ==========================================================
  // Datapath and control state
  logic [LANES*BITS_PER_LANE-1:0] bits_r, bits_nxt, cap_r, cap_nxt;
  tlds_state_type st_r, st_nxt;
  logic [2:0] good_r, good_nxt;
  tlds_out_type out_r, out_nxt;
  logic rise, steady, loss;

  assign rise = clk_s & ~clk_d_r;
  assign steady = (per_nxt <= per_r + CNT_W'(1)) &&
                  (per_nxt + CNT_W'(1) >= per_r);
  assign loss = (cnt_r == LOSS_CYC);

  // Next values of counters, sample store, state and outputs
  always_comb begin
    cnt_nxt = cnt_r;
    per_nxt = per_r;
    prev_nxt = prev_r;
    bits_nxt = bits_r;
    cap_nxt = cap_r;
    st_nxt = st_r;
    good_nxt = good_r;
    out_nxt = out_r;
    // Period measured every rising edge; counter saturates when clock stops
    if (rise) begin
      cnt_nxt = '0;
      per_nxt = cnt_r + CNT_W'(1);
      prev_nxt = per_r;
    end else if (!loss) begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
    for (int n = 0; n < LANES; n++) begin
      for (int b = 0; b < BITS_PER_LANE; b++) begin
        if (hit[b]) begin
          bits_nxt[n*BITS_PER_LANE+b] = lane_d_r[n];
        end
      end
    end
    unique case (st_r)
      TLDS_SLEEP: begin
        out_nxt = '{word: WORD_RST, strobe: 1'b0};
        good_nxt = '0;
        if (sleep_s) begin
          st_nxt = TLDS_ACQ;
        end
      end
      TLDS_ACQ: begin
        out_nxt.strobe = 1'b0;
        if (rise) begin
          // Last bit may be sampled in the edge cycle itself
          cap_nxt = bits_nxt;
          if (!steady) begin
            good_nxt = '0;
          end else if (good_r == LOCK_EDGES - 3'h1) begin
            st_nxt = TLDS_LOCK;
          end else begin
            good_nxt = good_r + 3'h1;
          end
        end else if (loss) begin
          st_nxt = TLDS_LOST;
        end
      end
      TLDS_LOCK: begin
        if (rise) begin
          // Word of period n-1 goes out while period n+1 is sampled
          cap_nxt = bits_nxt;
          out_nxt.word = cap_r;
          out_nxt.strobe = 1'b0;
          if (!steady) begin
            st_nxt = TLDS_ACQ;
            good_nxt = '0;
          end
        end else if (loss) begin
          st_nxt = TLDS_LOST;
        end else if (cnt_r == (per_r >> 1)) begin
          // Rise in mid-period gives the word half a period of setup
          out_nxt.strobe = 1'b1;
        end
      end
      TLDS_LOST: begin
        out_nxt.strobe = 1'b1;
        good_nxt = '0;
        if (rise) begin
          st_nxt = TLDS_ACQ;
        end
      end
    endcase
    // Sleep overrides state and outputs in the cycle it is seen
    if (!sleep_s) begin
      st_nxt = TLDS_SLEEP;
      out_nxt = '{word: WORD_RST, strobe: 1'b0};
    end
  end

  // Register the next values
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      per_r <= '0;
      prev_r <= '0;
      bits_r <= WORD_RST;
      cap_r <= WORD_RST;
      st_r <= TLDS_SLEEP;
      good_r <= '0;
      out_r <= '{word: WORD_RST, strobe: 1'b0};
    end else begin
      cnt_r <= cnt_nxt;
      per_r <= per_nxt;
      prev_r <= prev_nxt;
      bits_r <= bits_nxt;
      cap_r <= cap_nxt;
      st_r <= st_nxt;
      good_r <= good_nxt;
      out_r <= out_nxt;
    end
  end

  assign parallel_word_out = out_r;

  // ==========================================================
  // Checks
  logic [CNT_W-1:0] slp_cnt_r;
  logic [31:0] acq_cyc_r;

  // Helper counters: cycles with sleep_n low, cycles spent acquiring
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      slp_cnt_r <= '0;
      acq_cyc_r <= '0;
    end else begin
      if (sleep_n) begin
        slp_cnt_r <= '0;
      end else if (slp_cnt_r != 8'hFF) begin
        slp_cnt_r <= slp_cnt_r + 8'h01;
      end
      if (st_r == TLDS_ACQ && sync2_r[LANES+1]) begin
        acq_cyc_r <= acq_cyc_r + 32'h00000001;
      end else begin
        acq_cyc_r <= '0;
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sample_bit_a: assert property (hit[0] |=>
    bits_r[0] == $past(lane_d_r[0]))
    else $error("bit 0 of lane 0 not sampled at its position");
  sleep_low_a: assert property (!sleep_s |=>
    out_r.word == WORD_RST && !out_r.strobe)
    else $error("outputs not low while asleep");
  sleep_delay_a: assert property (
    slp_cnt_r >= 8'(SLEEP_ENTRY_CYC) |-> out_r == '0)
    else $error("outputs not low within sleep entry delay");
  word_move_a: assert property (st_r == TLDS_LOCK && rise && sleep_s
    |=> out_r.word == $past(cap_r) && cap_r == $past(bits_nxt))
    else $error("word pipeline did not advance on link edge");
  strobe_edge_a: assert property (st_r == TLDS_LOCK && rise && sleep_s
    |=> !out_r.strobe ##1 $stable(out_r.word))
    else $error("strobe not low with new word");
  lost_hold_a: assert property (st_r == TLDS_LOST && st_nxt == TLDS_LOST
    |=> out_r.strobe && $stable(out_r.word))
    else $error("lost clock did not hold word and raise strobe");
  lock_time_a: assert property (acq_cyc_r < 32'(LOCK_LIMIT_CYC))
    else $error("lock not reached in time");
  period_track_a: assert property (rise |=>
    per_r == $past(cnt_r) + 8'h01)
    else $error("link period not measured");

  lock_seen_c: cover property (st_r == TLDS_ACQ ##1 st_r == TLDS_LOCK);
  loss_seen_c: cover property (st_r == TLDS_LOCK ##1 st_r == TLDS_LOST);
  sleep_seen_c: cover property (st_r == TLDS_LOCK ##1 st_r == TLDS_SLEEP);
  strobe_seen_c: cover property ($rose(out_r.strobe));

endmodule
`default_nettype wire

// File: verif/tlds_rx_tb.sv
// Self-checking bench for the deserializer with a transmitter model.
// Assumes a 100 MHz sys_clk and a 125 ns forwarded link period.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_fail++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
  end end
module tlds_rx_tb
  import tlds_pkg::*;
;
  // ==========================================================
  // Signals and instances
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sleep_n = 1'b1;
  logic run = 1'b0;
  logic float_data = 1'b0;
  logic ok_r;
  logic [WORD_W-1:0] tx_word = 21'h000000;
  logic forwarded_link_clock;
  logic [LANES-1:0] serial_data_lane;
  tlds_out_type pwo;
  int n_fail = 0;
  int samples_checked = 0;
  time t_r;
  tlds_rx #(.LOCK_LIMIT_CYC(2000)) tlds_rx_i (.sys_clk(sys_clk),
    .arst_n(arst_n), .forwarded_link_clock(forwarded_link_clock),
    .serial_data_lane(serial_data_lane), .sleep_n(sleep_n),
    .parallel_word_out(pwo));
  tlds_tx_model tlds_tx_model_i (.run(run), .float_data(float_data),
    .tx_word(tx_word), .forwarded_link_clock(forwarded_link_clock),
    .serial_data_lane(serial_data_lane));
  // Free-running system clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // Shared tasks
  // Bounded wait for a strobe rise, sampled on the falling edge
  task automatic wait_rise();
    logic p;
    p = pwo.strobe;
    ok_r = 1'b0;
    for (int i = 0; i < 3000 && !ok_r; i++) begin
      @(negedge sys_clk);
      ok_r = (p === 1'b0 && pwo.strobe === 1'b1);
      p = pwo.strobe;
    end
    t_r = $time;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  // Lock, then each word shows on the fourth strobe rise after it is set
  task automatic t_data();
    logic [WORD_W-1:0] pats [4] = '{21'h000001, 21'h000080, 21'h100000,
      21'h0A5F3C};
    logic [WORD_W-1:0] old;
    time t0;
    old = 21'h000000;
    run = 1'b1;
    wait_rise();
    `CHK("lock", 1'b1, ok_r)
    for (int i = 0; i < 4; i++) begin
      @(posedge forwarded_link_clock);
      #1 tx_word = pats[i];
      for (int r = 0; r < 3; r++) begin
        wait_rise();
        `CHK("word_old", old, pwo.word)
      end
      t0 = t_r;
      wait_rise();
      `CHK("word_new", pats[i], pwo.word)
      `CHK("mapping", pats[i], pwo.word)
      `CHK("period", 1'b1, (t_r - t0 >= 120 && t_r - t0 <= 130))
      old = pats[i];
    end
    $display("test data done");
  endtask
  // Sleep clears outputs in time, and leaving it relocks
  task automatic t_sleep();
    int n;
    @(posedge sys_clk);
    sleep_n <= 1'b0;
    n = 0;
    while (pwo !== '0 && n <= SLEEP_ENTRY_CYC) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("sleep_time", 1'b1, n <= SLEEP_ENTRY_CYC)
    repeat (40) @(posedge sys_clk);
    #1 `CHK("sleep_out", 22'h000000, pwo)
    @(posedge sys_clk);
    sleep_n <= 1'b1;
    wait_rise();
    wait_rise();
    `CHK("relock", {1'b1, tx_word}, {ok_r, pwo.word})
    $display("test sleep done");
  endtask
  // Released data lanes read high; then a stopped clock holds the word
  task automatic t_fail_safe();
    float_data = 1'b1;
    repeat (4) wait_rise();
    `CHK("float_word", 21'h1FFFFF, pwo.word)
    run = 1'b0;
    repeat (int'(LOSS_CYC) + 30) @(posedge sys_clk);
    #1 `CHK("lost_out", 22'h3FFFFF, pwo)
    $display("test fail_safe done");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_data();
    t_sleep();
    t_fail_safe();
    give_verdict();
  end
  // Tests need under 1000 cycles; far beyond that means a hang
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire

// File: verif/tlds_tx_model.sv
// Behavioural serializing transmitter feeding the deserializer's link pins.
// Assumes the bench picks the word per frame and starts or stops frames.
`timescale 1ns/1ns
`default_nettype none
module tlds_tx_model
  import tlds_pkg::*;
(
  input wire logic run, // Send frames while high
  input wire logic float_data, // Data lanes released
  input wire logic [WORD_W-1:0] tx_word, // Word latched at frame start
  output logic forwarded_link_clock, // Forwarded clock lane
  output logic [LANES-1:0] serial_data_lane // Serial data lanes
);
  // ==========================================================
  // Frame generator
  localparam int PER_NS = 125;
  logic [WORD_W-1:0] cur;
  // One frame is seven bit slots; clock high for the first four
  initial begin
    forwarded_link_clock = 1'b1;
    serial_data_lane = '1;
    // Start 3 ns off the grid so no link clock edge meets a sys_clk rise
    #3;
    forever begin
      if (!run) begin
        // Released pins fail safe high, so an idle clock stands high
        forwarded_link_clock = 1'b1;
        serial_data_lane = '1;
        #5;
      end else begin
        cur = tx_word;
        for (int k = 0; k < BITS_PER_LANE; k++) begin
          forwarded_link_clock = (k < 4);
          // First slot is 17 ns and the other six 18 ns to keep 125 ns frames
          for (int n = 0; n < LANES; n++) begin
            serial_data_lane[n] = float_data | cur[n*BITS_PER_LANE+k];
          end
          #(((k + 1) * PER_NS) / 7 - (k * PER_NS) / 7);
        end
      end
    end
  end
endmodule
`default_nettype wire
